// >>> verilog/ovrd_top.v
// Top of the over-range detector: APB registers, four channels, pins, interrupt.
//
// Contract
// - Over-range checks use each channel's samples directly at the converter output.
// - Each sample gives an 11-bit magnitude whose upper 8 bits are compared to the threshold.
// - Mid-scale maps to zero, symmetric codes match, and the most negative code gives 255.
// - One shared threshold serves every channel.
// - Detection works only while the detection enable is 1.
// - A flag is 1 when the compared value is at or above the threshold in the hold period.
// - The four-channel variant drives flags for channels A, B, C and D.
// - The two-channel variant drives flags for channels A and B.
// - The single-channel variant drives only the channel A flag.
// - The 3-bit hold select gives a flag length of 8 times two to the select, 8 to 1024 cycles.
// - Every new exceeding sample restarts the hold countdown.
// - Samples are read as signed two's complement before the magnitude is formed.
// - A reference clock function on pin C or D overrides that pin's flag.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_consts.vh"
module ovrd_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [1:0]  variant_sel,
    input  wire [11:0] sample_a,
    input  wire [11:0] sample_b,
    input  wire [11:0] sample_c,
    input  wire [11:0] sample_d,
    input  wire        ref_clk_c,
    input  wire        ref_clk_d,
    output wire        flag_out_ch_a,
    output wire        flag_out_ch_b,
    output wire        flag_out_ch_c,
    output wire        flag_out_ch_d,
    output wire        irq
);
    localparam [1:0] VAR_QUAD   = 2'h0;
    localparam [1:0] VAR_DUAL   = 2'h1;

    reg                    overrange_detect_enable_q;
    reg  [2:0]             flag_hold_length_select_q;
    reg  [`OVRD_CMP_W-1:0] overrange_threshold_q;
    reg                    ref_clock_output_c_function_q;
    reg                    ref_clock_output_d_function_q;
    reg  [3:0]             status_q;
    reg  [3:0]             irq_en_q;
    reg  [3:0]             flag_prev_q;
    wire [3:0]             flag;
    wire [3:0]             chan_on;
    wire [3:0]             rise;
    wire [3:0]             clr;
    wire [3:0]             pin;
    wire [47:0]            samples;
    wire                   wr;
    wire                   rd;
    wire                   addr_ok;
    reg  [31:0]            rdata_d;
    genvar                 g;

    assign samples = {sample_d, sample_c, sample_b, sample_a};

    // Channels present depend on the variant.
    assign chan_on = (variant_sel == VAR_QUAD) ? 4'hF :
                     (variant_sel == VAR_DUAL) ? 4'h3 : 4'h1;

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            // All channels share one threshold.
            ovrd_channel u_ch (
                .pclk      (pclk),
                .presetn   (presetn),
                .clk_en    (clk_en),
                .enable    (overrange_detect_enable_q & chan_on[g]),
                .sample    (samples[g*12 +: 12]),
                .threshold (overrange_threshold_q),
                .hold_sel  (flag_hold_length_select_q),
                .flag_q    (flag[g]),
                .event_hit ()
            );
        end
    endgenerate

    // Reference clock function wins over the flag on pins C and D.
    assign pin[0] = flag[0];
    assign pin[1] = flag[1];
    assign pin[2] = ref_clock_output_c_function_q ? ref_clk_c : flag[2];
    assign pin[3] = ref_clock_output_d_function_q ? ref_clk_d : flag[3];
    assign flag_out_ch_a = pin[0];
    assign flag_out_ch_b = pin[1];
    assign flag_out_ch_c = pin[2];
    assign flag_out_ch_d = pin[3];

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign addr_ok = (paddr <= `OVRD_OFF_FLAGS) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !addr_ok;

    assign rise = flag & ~flag_prev_q;
    assign clr  = (wr && paddr == `OVRD_OFF_CLEAR) ? pwdata[3:0] : 4'h0;
    assign irq  = |(status_q & irq_en_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrange_detect_enable_q     <= 1'b0;
            flag_hold_length_select_q     <= 3'h0;
            overrange_threshold_q         <= `OVRD_RST_THRESH;
            ref_clock_output_c_function_q <= 1'b0;
            ref_clock_output_d_function_q <= 1'b0;
            irq_en_q                      <= 4'h0;
            status_q                      <= 4'h0;
            flag_prev_q                   <= 4'h0;
        end else if (clk_en) begin
            flag_prev_q <= flag;
            // A new flag rise wins over a clear in the same cycle.
            status_q <= (status_q & ~clr) | rise;
            if (wr) begin
                case (paddr)
                    `OVRD_OFF_CTRL: begin
                        overrange_detect_enable_q <= pwdata[`OVRD_CTRL_EN_BIT];
                        flag_hold_length_select_q <=
                            pwdata[`OVRD_CTRL_HOLD_MSB:`OVRD_CTRL_HOLD_LSB];
                    end
                    `OVRD_OFF_THRESH: begin
                        overrange_threshold_q <= pwdata[7:0];
                    end
                    `OVRD_OFF_FUNC: begin
                        ref_clock_output_c_function_q <= pwdata[`OVRD_FUNC_C_BIT];
                        ref_clock_output_d_function_q <= pwdata[`OVRD_FUNC_D_BIT];
                    end
                    `OVRD_OFF_IRQ_EN: begin
                        irq_en_q <= pwdata[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        case (paddr)
            `OVRD_OFF_CTRL: begin
                rdata_d = {25'h0, flag_hold_length_select_q, 3'h0,
                           overrange_detect_enable_q};
            end
            `OVRD_OFF_THRESH: begin
                rdata_d = {24'h000000, overrange_threshold_q};
            end
            `OVRD_OFF_FUNC: begin
                rdata_d = {30'h0, ref_clock_output_d_function_q,
                           ref_clock_output_c_function_q};
            end
            `OVRD_OFF_STATUS: begin
                rdata_d = {28'h0000000, status_q};
            end
            `OVRD_OFF_IRQ_EN: begin
                rdata_d = {28'h0000000, irq_en_q};
            end
            `OVRD_OFF_FLAGS: begin
                rdata_d = {28'h0000000, flag};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // Read data is captured in the setup cycle so it is valid in the access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && rd && !penable) begin
            prdata <= rdata_d;
        end
    end
endmodule // ovrd_top
`default_nettype wire

// >>> pkg/ovrd_consts.vh
// Constants for the over-range detector: register offsets, fields, reset values.
`ifndef OVRD_CONSTS_VH
`define OVRD_CONSTS_VH
`define OVRD_OFF_CTRL        12'h000
`define OVRD_OFF_THRESH      12'h004
`define OVRD_OFF_FUNC        12'h008
`define OVRD_OFF_STATUS      12'h00C
`define OVRD_OFF_CLEAR       12'h010
`define OVRD_OFF_IRQ_EN      12'h014
`define OVRD_OFF_FLAGS       12'h018
`define OVRD_CTRL_EN_BIT     0
`define OVRD_CTRL_HOLD_LSB   4
`define OVRD_CTRL_HOLD_MSB   6
`define OVRD_FUNC_C_BIT      0
`define OVRD_FUNC_D_BIT      1
`define OVRD_RST_CTRL        32'h00000000
`define OVRD_RST_THRESH      8'hE4
`define OVRD_HOLD_BASE_LOG2  3
`define OVRD_CNT_W           11
`define OVRD_SAMPLE_W        12
`define OVRD_MAG_W           11
`define OVRD_CMP_W           8
`define OVRD_MAG_MAX         11'h7FF
`endif

// >>> verilog/ovrd_magnitude.v
// Sample-to-magnitude converter producing the 8-bit compared value.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_consts.vh"
module ovrd_magnitude (
    input  wire [`OVRD_SAMPLE_W-1:0] sample,
    output wire [`OVRD_CMP_W-1:0]    cmp_value
);
    wire [`OVRD_SAMPLE_W-1:0] neg_val;
    wire [`OVRD_MAG_W-1:0]    mag;

    // Sample is two's complement; negative values are negated.
    assign neg_val = (~sample) + 12'h001;
    // Most negative code saturates to full magnitude.
    assign mag = !sample[`OVRD_SAMPLE_W-1] ? sample[`OVRD_MAG_W-1:0] :
                 (sample == 12'h800) ? `OVRD_MAG_MAX : neg_val[`OVRD_MAG_W-1:0];
    // Only the upper eight magnitude bits are compared.
    assign cmp_value = mag[`OVRD_MAG_W-1:`OVRD_MAG_W-`OVRD_CMP_W];
endmodule // ovrd_magnitude
`default_nettype wire

// >>> verilog/ovrd_channel.v
// One channel of over-range detection with its hold counter and flag.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_consts.vh"
module ovrd_channel (
    input  wire                      pclk,
    input  wire                      presetn,
    input  wire                      clk_en,
    input  wire                      enable,
    input  wire [`OVRD_SAMPLE_W-1:0] sample,
    input  wire [`OVRD_CMP_W-1:0]    threshold,
    input  wire [2:0]                hold_sel,
    output reg                       flag_q,
    output wire                      event_hit
);
    wire [`OVRD_CMP_W-1:0]  cmp_value;
    wire [`OVRD_CNT_W-1:0]  hold_len;
    reg  [`OVRD_CNT_W-1:0]  cnt_q;

    // Magnitude is taken straight from the converter sample.
    ovrd_magnitude u_mag (
        .sample    (sample),
        .cmp_value (cmp_value)
    );

    // Hold length is 8 shifted left by the select value.
    assign hold_len = 11'h008 << hold_sel;
    // Greater than or equal compare, only while enabled.
    assign event_hit = enable && (cmp_value >= threshold);

    // Each channel counts independently and registers its flag.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 11'h000;
            flag_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable) begin
                cnt_q  <= 11'h000;
                flag_q <= 1'b0;
            end else if (event_hit) begin
                cnt_q  <= hold_len - 11'h001;
                flag_q <= 1'b1;
            end else if (cnt_q != 11'h000) begin
                cnt_q  <= cnt_q - 11'h001;
                flag_q <= 1'b1;
            end else begin
                flag_q <= 1'b0;
            end
        end
    end
endmodule // ovrd_channel
`default_nettype wire

// >>> dv/ovrd_top_props.sv
// Port assertions for the over-range detector.
`timescale 1ns/1ps
`default_nettype none
module ovrd_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [1:0]  variant_sel,
    input wire logic        ref_clk_c,
    input wire logic        flag_out_ch_a,
    input wire logic        flag_out_ch_b,
    input wire logic        flag_out_ch_c
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; psel && penable && (paddr > 12'h018 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("pslverr missing");
    property p_ok; psel && penable && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("pslverr on mapped");
    property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
    property p_freeze; !clk_en |=> $stable(flag_out_ch_a); endproperty
    a_freeze: assert property (p_freeze) else $error("flag moved while frozen");
    property p_hold_min;
        $rose(flag_out_ch_a) |-> (flag_out_ch_a || $past(psel, 2) || $past(psel, 3))[*8];
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("flag pulse short");
    property p_b_off; (variant_sel[1] && clk_en)[*3] |-> !flag_out_ch_b; endproperty
    a_b_off: assert property (p_b_off) else $error("flag b in single");
    property p_c_off; (variant_sel != 2'h0 && clk_en)[*3] ##0 !ref_clk_c |-> !flag_out_ch_c;
    endproperty
    a_c_off: assert property (p_c_off) else $error("flag c absent chan");
endmodule // ovrd_top_props
bind ovrd_top ovrd_top_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .variant_sel(variant_sel), .ref_clk_c(ref_clk_c),
    .flag_out_ch_a(flag_out_ch_a), .flag_out_ch_b(flag_out_ch_b),
    .flag_out_ch_c(flag_out_ch_c));
`default_nettype wire

// >>> dv/ovrd_gain_model.sv
// Downstream gain controller model driven by the channel A flag.
`timescale 1ns/1ps
`default_nettype none
module ovrd_gain_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        flag,
    input  wire logic [11:0] sample,
    output var  logic        gain_low_q
);
    // Gain rises again only once its own view of the samples is quiet.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_low_q <= 1'b0;
        end else if (flag) begin
            gain_low_q <= 1'b1;
        end else if (sample == 12'h000) begin
            gain_low_q <= 1'b0;
        end
    end
endmodule // ovrd_gain_model
`default_nettype wire

// >>> dv/adc_overrange_detector_bench.sv
// Self-checking testbench for the over-range detector.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_consts.vh"
module adc_overrange_detector_bench;
    logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ref_clk_c = 1'b0, ref_clk_d = 1'b0, er;
    logic [11:0] paddr = 12'h000, smp = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [1:0]  variant_sel = 2'h0;
    wire         pready, pslverr, irq, fa, fb, fc, fd, gain_low_q;
    wire  [31:0] prdata;
    integer      err_count = 0, total_checks = 0, cyc = 0, n;
    ovrd_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .variant_sel(variant_sel), .sample_a(smp),
        .sample_b(smp), .sample_c(smp), .sample_d(smp), .ref_clk_c(ref_clk_c),
        .ref_clk_d(ref_clk_d), .flag_out_ch_a(fa), .flag_out_ch_b(fb), .flag_out_ch_c(fc),
        .flag_out_ch_d(fd), .irq(irq));
    ovrd_gain_model u_far (.pclk(pclk), .presetn(presetn), .flag(fa), .sample(smp),
        .gain_low_q(gain_low_q));
    always #50 pclk = ~pclk;
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk("prdata", rd, exp);
        chk("pslverr", {31'h0, er}, {31'h0, e});
    endtask
    task automatic hit(input logic [11:0] s);
        @(posedge pclk);
        smp <= s;
        @(posedge pclk);
        smp <= 12'h000;
        @(negedge pclk);
    endtask
    task automatic t_regs;
        rchk(`OVRD_OFF_CTRL, 32'h0, 1'b0);
        rchk(`OVRD_OFF_THRESH, 32'h000000E4, 1'b0);
        rchk(`OVRD_OFF_CLEAR, 32'h0, 1'b0);
        rchk(12'h01C, 32'h0, 1'b1);
        $display("test registers done");
    endtask
    task automatic t_mag;
        logic [11:0] s [5] = '{12'h800, 12'h810, 12'h7F0, 12'h7EF, 12'h000};
        logic        e [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        apb(1'b1, `OVRD_OFF_CTRL, 32'h1);
        apb(1'b1, `OVRD_OFF_THRESH, 32'hFE);
        for (int i = 0; i < 5; i++) begin
            hit(s[i]);
            chk("flags", {28'h0, fa, fb, fc, fd}, {28'h0, {4{e[i]}}});
            repeat (10) @(posedge pclk);
        end
        $display("test magnitude done");
    endtask
    task automatic t_hold;
        apb(1'b1, `OVRD_OFF_THRESH, 32'hE4);
        for (int s = 0; s < 9; s++) begin
            apb(1'b1, `OVRD_OFF_CTRL, 32'((s % 8) * 16 + 1));
            rchk(`OVRD_OFF_CTRL, 32'((s % 8) * 16 + 1), 1'b0);
            hit(12'h800);
            if (s == 8) hit(12'h800);
            n = 0;
            while (fa === 1'b1 && n < 1100) begin
                n = n + 1;
                @(negedge pclk);
            end
            chk("hold", 32'(n), 32'(8 << (s % 8)));
        end
        $display("test hold done");
    endtask
    task automatic t_irq;
        apb(1'b1, `OVRD_OFF_IRQ_EN, 32'hF);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, `OVRD_OFF_CLEAR, 32'hF);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rchk(`OVRD_OFF_STATUS, 32'h0, 1'b0);
        hit(12'h800);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk(`OVRD_OFF_FLAGS, 32'hF, 1'b0);
        rchk(`OVRD_OFF_STATUS, 32'hF, 1'b0);
        apb(1'b1, `OVRD_OFF_IRQ_EN, 32'h0);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
    endtask
    task automatic t_variant;
        logic [1:0] v [3] = '{2'h1, 2'h2, 2'h0};
        logic [3:0] e [3] = '{4'hC, 4'h8, 4'hD};
        for (int i = 0; i < 3; i++) begin
            repeat (12) @(posedge pclk);
            variant_sel <= v[i];
            ref_clk_d <= (i == 2);
            if (i == 2) apb(1'b1, `OVRD_OFF_FUNC, 32'h3);
            hit(12'h800);
            chk("flags", {28'h0, fa, fb, fc, fd}, {28'h0, e[i]});
        end
        @(posedge pclk);
        ref_clk_c <= 1'b1;
        ref_clk_d <= 1'b0;
        @(negedge pclk);
        chk("refclk", {28'h0, fa, fb, fc, fd}, 32'hE);
        rchk(`OVRD_OFF_FUNC, 32'h3, 1'b0);
        apb(1'b1, `OVRD_OFF_FUNC, 32'h0);
        $display("test variants done");
    endtask
    task automatic t_disable;
        repeat (12) @(posedge pclk);
        apb(1'b1, `OVRD_OFF_CTRL, 32'h0);
        hit(12'h800);
        chk("flags", {28'h0, fa, fb, fc, fd}, 32'h0);
        apb(1'b1, `OVRD_OFF_CTRL, 32'h1);
        hit(12'h800);
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        clk_en <= 1'b1;
        @(negedge pclk);
        chk("frozen", {30'h0, fa, gain_low_q}, 32'h3);
        repeat (12) @(negedge pclk);
        chk("released", {30'h0, fa, gain_low_q}, 32'h0);
        $display("test disable done");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_mag;
        t_hold;
        t_irq;
        t_variant;
        t_disable;
        finish_test;
    end
endmodule // adc_overrange_detector_bench
`default_nettype wire
